// ==== logic/debug_and_boundary_scan_port.sv ====
// test access port with debug chains, boundary scan and identification
`timescale 1ns/1ns
module debug_and_boundary_scan_port (
  input wire logic CLK_SYS_I,                   // master clock, 50 MHz
  input wire logic CHIP_RESET_N_I,                      // chip reset, active low
  input wire logic FACTORY_TEST_PIN_I,          // factory test pin
  input wire logic PORT_MODE_SELECTION_I,       // 0 debug, 1 boundary scan
  input wire logic DEBUG_LOGIC_RESET_N_I,       // debug logic reset pin
  input wire logic TCK_I,                       // test clock pin
  input wire logic TMS_I,                       // test mode select pin
  input wire logic TDI_I,                       // test data in pin
  output logic TDO_O,                           // test data out
  output logic TDO_OE_O,                        // test data out enable
  output logic RETURNED_TEST_CLOCK_O,           // returned test clock
  output logic BSC_MODE_O,                      // latched scan mode
  input wire logic [7:0] PAD_IN_I,              // pin levels seen by cells
  input wire logic [7:0] CORE_PAD_OUT_I,        // core levels for pins
  output logic [7:0] PAD_OUT_O,                 // levels driven to pins
  input wire logic [31:0] CORE_DATA_I,          // core data for capture
  output dbg_port_pkg::dbg_out_t DBG_O,         // words to the core
  input wire logic COMM_CHANNEL_TX_FLAG_I,      // comm channel tx flag
  input wire logic COMM_CHANNEL_RX_FLAG_I,      // comm channel rx flag
  output logic COMM_IRQ_O,                      // comm channel interrupt
  input wire logic SYS_ACCESS_BLOCK_I,          // block debug system access
  output logic [31:0] CHIP_ID_O,                // chip identification
  input wire logic DEBUG_SERIAL_RX_I,           // serial receive pin
  output logic DEBUG_SERIAL_TX_O,               // serial transmit pin
  output logic SERIAL_RX_LEVEL_O,               // receive level to channel
  input wire logic SERIAL_TX_LEVEL_I            // transmit level from channel
);
  typedef struct packed {
    dbg_port_pkg::tap_state_t st;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [31:0] dr_sh;
    logic [7:0] bsr_upd;
    logic [7:0] pad_out;
    logic [3:0] scan_sel;
    dbg_port_pkg::dbg_out_t dout;
    logic tdo;
    logic tdo_oe;
    logic returned_test_clock;
    logic tck_prev;
    logic [4:0] por_cnt;
    logic bsc_mode;
    logic mode_valid;
    logic irq;
    logic tx;
  } state_t;

  state_t q;
  state_t d;
  logic [6:0] sync_s;
  logic tck_s, tms_s, tdi_s, trst_n_s, sel_s, test_s, rx_s;
  logic tck_rise, tck_fall;
  dbg_port_pkg::dr_kind_t kind;

  dbg_sync2 #(.W(dbg_port_pkg::SYNC_W)) u_sync (
    .clk_i(CLK_SYS_I),
    .chip_reset_n_i(CHIP_RESET_N_I),
    .async_i({TCK_I, TMS_I, TDI_I, DEBUG_LOGIC_RESET_N_I, PORT_MODE_SELECTION_I,
      FACTORY_TEST_PIN_I, DEBUG_SERIAL_RX_I}),
    .sync_o(sync_s)
  );
  assign {tck_s, tms_s, tdi_s, trst_n_s, sel_s, test_s, rx_s} = sync_s;
  assign tck_rise = tck_s & ~q.tck_prev;
  assign tck_fall = ~tck_s & q.tck_prev;

  function automatic dbg_port_pkg::tap_state_t next_st(dbg_port_pkg::tap_state_t s,
      logic tms);
    dbg_port_pkg::tap_state_t n;
    n = s;
    unique case (s)
      dbg_port_pkg::TAP_RESET: n = tms ? dbg_port_pkg::TAP_RESET : dbg_port_pkg::TAP_IDLE;
      dbg_port_pkg::TAP_IDLE: n = tms ? dbg_port_pkg::TAP_SEL_DR : dbg_port_pkg::TAP_IDLE;
      dbg_port_pkg::TAP_SEL_DR: n = tms ? dbg_port_pkg::TAP_SEL_IR : dbg_port_pkg::TAP_CAP_DR;
      dbg_port_pkg::TAP_CAP_DR: n = tms ? dbg_port_pkg::TAP_EX1_DR : dbg_port_pkg::TAP_SH_DR;
      dbg_port_pkg::TAP_SH_DR: n = tms ? dbg_port_pkg::TAP_EX1_DR : dbg_port_pkg::TAP_SH_DR;
      dbg_port_pkg::TAP_EX1_DR: n = tms ? dbg_port_pkg::TAP_UPD_DR : dbg_port_pkg::TAP_PAU_DR;
      dbg_port_pkg::TAP_PAU_DR: n = tms ? dbg_port_pkg::TAP_EX2_DR : dbg_port_pkg::TAP_PAU_DR;
      dbg_port_pkg::TAP_EX2_DR: n = tms ? dbg_port_pkg::TAP_UPD_DR : dbg_port_pkg::TAP_SH_DR;
      dbg_port_pkg::TAP_UPD_DR: n = tms ? dbg_port_pkg::TAP_SEL_DR : dbg_port_pkg::TAP_IDLE;
      dbg_port_pkg::TAP_SEL_IR: n = tms ? dbg_port_pkg::TAP_RESET : dbg_port_pkg::TAP_CAP_IR;
      dbg_port_pkg::TAP_CAP_IR: n = tms ? dbg_port_pkg::TAP_EX1_IR : dbg_port_pkg::TAP_SH_IR;
      dbg_port_pkg::TAP_SH_IR: n = tms ? dbg_port_pkg::TAP_EX1_IR : dbg_port_pkg::TAP_SH_IR;
      dbg_port_pkg::TAP_EX1_IR: n = tms ? dbg_port_pkg::TAP_UPD_IR : dbg_port_pkg::TAP_PAU_IR;
      dbg_port_pkg::TAP_PAU_IR: n = tms ? dbg_port_pkg::TAP_EX2_IR : dbg_port_pkg::TAP_PAU_IR;
      dbg_port_pkg::TAP_EX2_IR: n = tms ? dbg_port_pkg::TAP_UPD_IR : dbg_port_pkg::TAP_SH_IR;
      dbg_port_pkg::TAP_UPD_IR: n = tms ? dbg_port_pkg::TAP_SEL_DR : dbg_port_pkg::TAP_IDLE;
    endcase
    return n;
  endfunction

  // shift right, new bit enters at the top of the selected length
  function automatic logic [31:0] shift_dr(logic [31:0] v, int len, logic b);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      if (i == len - 1) begin
        r[i] = b;
      end else if (i < len - 1) begin
        r[i] = v[i + 1];
      end
    end
    return r;
  endfunction

  // selected data register from mode and instruction
  always_comb begin
    kind = dbg_port_pkg::DR_BYPASS;
    if (q.bsc_mode) begin
      if (q.ir == dbg_port_pkg::IR_EXTEST || q.ir == dbg_port_pkg::IR_SAMPLE) begin
        kind = dbg_port_pkg::DR_BSR;
      end else if (q.ir == dbg_port_pkg::IR_IDCODE) begin
        kind = dbg_port_pkg::DR_IDCODE;
      end
    end else begin
      if (q.ir == dbg_port_pkg::IR_IDCODE) begin
        kind = dbg_port_pkg::DR_IDCODE;
      end else if (q.ir == dbg_port_pkg::IR_SCAN_N) begin
        kind = dbg_port_pkg::DR_SCANSEL;
      end else if (q.ir == dbg_port_pkg::IR_INTEST) begin
        if (q.scan_sel == dbg_port_pkg::CHAIN_INSN) begin
          kind = dbg_port_pkg::DR_INSN;
        end else if (q.scan_sel == dbg_port_pkg::CHAIN_DREG) begin
          kind = dbg_port_pkg::DR_DREG;
        end
      end
    end
  end

  always_comb begin
    d = q;
    d.tck_prev = tck_s;
    d.dout.insn_valid = 1'b0;
    d.dout.dreg_valid = 1'b0;
    d.returned_test_clock = q.mode_valid & ~q.bsc_mode & tck_s;
    d.irq = COMM_CHANNEL_TX_FLAG_I | COMM_CHANNEL_RX_FLAG_I;
    d.tx = SERIAL_TX_LEVEL_I;
    d.pad_out = (q.bsc_mode && q.ir == dbg_port_pkg::IR_EXTEST) ? q.bsr_upd
      : CORE_PAD_OUT_I;
    if (q.por_cnt != 5'h00) begin
      d.por_cnt = q.por_cnt - 5'h01;
    end
    if (!q.mode_valid && q.por_cnt == 5'h00) begin
      d.bsc_mode = sel_s;
      d.mode_valid = 1'b1;
    end
    if (q.por_cnt != 5'h00 || !trst_n_s || !q.mode_valid) begin
      d.st = dbg_port_pkg::TAP_RESET;
      d.ir = dbg_port_pkg::IR_IDCODE;
      d.tdo_oe = 1'b0;
    end else if (tck_rise) begin
      d.st = next_st(q.st, tms_s);
      unique case (q.st)
        dbg_port_pkg::TAP_RESET: begin
          d.ir = dbg_port_pkg::IR_IDCODE;
          d.scan_sel = dbg_port_pkg::SCAN_SEL_RST;
        end
        dbg_port_pkg::TAP_CAP_IR: d.ir_sh = dbg_port_pkg::IR_CAPTURE;
        dbg_port_pkg::TAP_SH_IR: d.ir_sh = {tdi_s, q.ir_sh[3:1]};
        dbg_port_pkg::TAP_UPD_IR: d.ir = q.ir_sh;
        dbg_port_pkg::TAP_SEL_IR: begin
          // high TMS here enters reset, which must reselect identification
          if (tms_s) begin
            d.ir = dbg_port_pkg::IR_IDCODE;
            d.scan_sel = dbg_port_pkg::SCAN_SEL_RST;
          end
        end
        dbg_port_pkg::TAP_CAP_DR: begin
          unique case (kind)
            dbg_port_pkg::DR_BYPASS: d.dr_sh = '0;
            dbg_port_pkg::DR_IDCODE: d.dr_sh = q.bsc_mode ? dbg_port_pkg::SCAN_IDCODE
              : dbg_port_pkg::PROC_ID;
            dbg_port_pkg::DR_BSR: d.dr_sh = {24'h000000, PAD_IN_I};
            dbg_port_pkg::DR_SCANSEL: d.dr_sh = {28'h0000000, q.scan_sel};
            dbg_port_pkg::DR_INSN: d.dr_sh = CORE_DATA_I;
            dbg_port_pkg::DR_DREG: d.dr_sh = {27'h0, test_s, SYS_ACCESS_BLOCK_I,
              COMM_CHANNEL_RX_FLAG_I, COMM_CHANNEL_TX_FLAG_I, 1'b1};
          endcase
        end
        dbg_port_pkg::TAP_SH_DR: begin
          unique case (kind)
            dbg_port_pkg::DR_BYPASS: d.dr_sh = shift_dr(q.dr_sh, 1, tdi_s);
            dbg_port_pkg::DR_BSR: d.dr_sh = shift_dr(q.dr_sh, dbg_port_pkg::BSR_LEN, tdi_s);
            dbg_port_pkg::DR_SCANSEL: d.dr_sh = shift_dr(q.dr_sh, dbg_port_pkg::IR_LEN, tdi_s);
            default: d.dr_sh = shift_dr(q.dr_sh, dbg_port_pkg::DR_LEN, tdi_s);
          endcase
        end
        dbg_port_pkg::TAP_UPD_DR: begin
          if (kind == dbg_port_pkg::DR_BSR) begin
            d.bsr_upd = q.dr_sh[7:0];
          end else if (kind == dbg_port_pkg::DR_SCANSEL) begin
            d.scan_sel = q.dr_sh[3:0];
          end else if (kind == dbg_port_pkg::DR_INSN && !SYS_ACCESS_BLOCK_I) begin
            d.dout.insn = q.dr_sh;
            d.dout.insn_valid = 1'b1;
          end else if (kind == dbg_port_pkg::DR_DREG && !SYS_ACCESS_BLOCK_I) begin
            d.dout.dreg = q.dr_sh;
            d.dout.dreg_valid = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (tck_fall) begin
      // data out changes on the falling test clock edge
      d.tdo_oe = (q.st == dbg_port_pkg::TAP_SH_IR) || (q.st == dbg_port_pkg::TAP_SH_DR);
      d.tdo = (q.st == dbg_port_pkg::TAP_SH_IR) ? q.ir_sh[0] : q.dr_sh[0];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge CHIP_RESET_N_I) begin
    if (!CHIP_RESET_N_I) begin
      q <= '0;
      q.st <= dbg_port_pkg::TAP_RESET;
      q.ir <= dbg_port_pkg::IR_IDCODE;
      q.scan_sel <= dbg_port_pkg::SCAN_SEL_RST;
      q.por_cnt <= dbg_port_pkg::POR_CNT_RST;
      q.tx <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign TDO_O = q.tdo;
  assign TDO_OE_O = q.tdo_oe;
  assign RETURNED_TEST_CLOCK_O = q.returned_test_clock;
  assign BSC_MODE_O = q.bsc_mode;
  assign PAD_OUT_O = q.pad_out;
  assign DBG_O = q.dout;
  assign COMM_IRQ_O = q.irq;
  assign CHIP_ID_O = dbg_port_pkg::CHIP_ID;
  assign DEBUG_SERIAL_TX_O = q.tx;
  assign SERIAL_RX_LEVEL_O = rx_s;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!CHIP_RESET_N_I);

  AST_MODE_HOLD: assert property (q.mode_valid |=> q.mode_valid && $stable(q.bsc_mode))
    else $error("scan mode changed without chip reset");
  AST_RETURNED_TEST_CLOCK_SCAN: assert property (q.bsc_mode |-> !q.returned_test_clock)
    else $error("returned clock active in boundary scan mode");
  AST_RETURNED_TEST_CLOCK_DEBUG: assert property (
    q.mode_valid && !q.bsc_mode && tck_s |=> RETURNED_TEST_CLOCK_O)
    else $error("returned clock missing in debug mode");
  AST_TMS_STEP: assert property (
    q.st == dbg_port_pkg::TAP_RESET && tck_rise && !tms_s && trst_n_s
    && q.por_cnt == 5'h00 && q.mode_valid |=> q.st == dbg_port_pkg::TAP_IDLE)
    else $error("controller did not leave reset on low TMS");
  AST_ID_AFTER_RESET: assert property (
    q.st == dbg_port_pkg::TAP_RESET && !tck_rise |=> q.ir == dbg_port_pkg::IR_IDCODE)
    else $error("identification not selected after reset");
  AST_ID_BIT0: assert property (
    tck_rise && q.st == dbg_port_pkg::TAP_CAP_DR && trst_n_s
    && q.por_cnt == 5'h00 && kind == dbg_port_pkg::DR_IDCODE && q.bsc_mode
    |=> q.dr_sh == dbg_port_pkg::SCAN_IDCODE && q.dr_sh[0])
    else $error("scan identification capture wrong");
  AST_PROC_ID: assert property (
    tck_rise && q.st == dbg_port_pkg::TAP_CAP_DR && trst_n_s
    && q.por_cnt == 5'h00 && kind == dbg_port_pkg::DR_IDCODE && !q.bsc_mode
    |=> q.dr_sh == dbg_port_pkg::PROC_ID)
    else $error("debug mode did not answer with processor id");
  AST_TDO_IDLE: assert property (
    tck_fall && trst_n_s && q.por_cnt == 5'h00
    && q.st == dbg_port_pkg::TAP_IDLE |=> !TDO_OE_O)
    else $error("data out enabled outside shift");
  AST_TDO_SHIFT: assert property (
    tck_fall && trst_n_s && q.por_cnt == 5'h00 && q.mode_valid
    && q.st == dbg_port_pkg::TAP_SH_DR |=> TDO_OE_O)
    else $error("data out not enabled while shifting");
  AST_EXTEST_DRIVE: assert property (
    q.bsc_mode && q.ir == dbg_port_pkg::IR_EXTEST
    ##1 $stable(q.bsr_upd) |-> PAD_OUT_O == q.bsr_upd)
    else $error("extest cells not driving pins");
  AST_POR_HOLD: assert property (
    $past(q.por_cnt) != 5'h00 |-> q.st == dbg_port_pkg::TAP_RESET)
    else $error("debug logic left reset during power-on hold");
  AST_BLOCK: assert property (
    SYS_ACCESS_BLOCK_I |=> !DBG_O.insn_valid && !DBG_O.dreg_valid)
    else $error("debug access passed while blocked");
  AST_IR_SHIFT: assert property (
    tck_rise && q.st == dbg_port_pkg::TAP_SH_IR && trst_n_s
    && q.por_cnt == 5'h00 && q.mode_valid |=> q.ir_sh[3] == $past(tdi_s))
    else $error("instruction shift lost data in bit");
  AST_IRQ: assert property (COMM_CHANNEL_RX_FLAG_I ##1 1'b1 |-> COMM_IRQ_O)
    else $error("comm flag did not raise interrupt");
  AST_IRQ_TX: assert property (COMM_CHANNEL_TX_FLAG_I |=> COMM_IRQ_O)
    else $error("tx flag did not raise interrupt");
endmodule

// ==== logic/dbg_port_pkg.sv ====
// shared constants, codes and carrier types of the debug and scan port
package dbg_port_pkg;
  localparam int BSR_LEN = 8;
  localparam int IR_LEN = 4;
  localparam int DR_LEN = 32;
  localparam int SYNC_W = 7;

  // instruction codes
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_SCAN_N = 4'h2;
  localparam logic [3:0] IR_INTEST = 4'hc;
  localparam logic [3:0] IR_IDCODE = 4'he;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // scan chain numbers written through the chain select register
  localparam logic [3:0] CHAIN_INSN = 4'h1;
  localparam logic [3:0] CHAIN_DREG = 4'h2;
  localparam logic [3:0] SCAN_SEL_RST = 4'h0;

  // identification fields; values arbitrary
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam logic [3:0] ID_VERSION = 4'h3;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MFR = 11'h2a5;
  localparam logic ID_MARKER = 1'b1;
  localparam logic [31:0] SCAN_IDCODE = (32'(ID_VERSION) << ID_VER_LSB)
    | (32'(ID_PART) << ID_PART_LSB) | (32'(ID_MFR) << ID_MFR_LSB) | 32'(ID_MARKER);
  // processor id and chip id; values arbitrary
  localparam logic [31:0] PROC_ID = 32'h4d3c_2b1a;
  localparam logic [31:0] CHIP_ID = 32'h6e70_0a10;

  // power-on hold of the debug logic
  localparam int CLK_PERIOD_NS = 20;
  localparam int POR_TIME_NS = 320;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] POR_CNT_RST = 5'(POR_CYCLES);

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR = 4'he,
    TAP_EX1_IR = 4'ha, TAP_PAU_IR = 4'hb, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
  } tap_state_t;

  typedef enum logic [2:0] {
    DR_BYPASS = 3'h0, DR_IDCODE = 3'h1, DR_BSR = 3'h3, DR_SCANSEL = 3'h2,
    DR_INSN = 3'h6, DR_DREG = 3'h7
  } dr_kind_t;

  // words handed to the processor core
  typedef struct packed {
    logic [31:0] insn;
    logic insn_valid;
    logic [31:0] dreg;
    logic dreg_valid;
  } dbg_out_t;
endpackage

// ==== logic/dbg_sync2.sv ====
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module dbg_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,           // sampling clock
  input wire logic chip_reset_n_i,          // async reset, active low
  input wire logic [W-1:0] async_i, // inputs from outside the domain
  output logic [W-1:0] sync_o       // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t q;
  sync_t d;

  always_comb begin
    d = q;
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i or negedge chip_reset_n_i) begin
    if (!chip_reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;
endmodule

// ==== tb/jtag_prober.sv ====
// tester model that drives the test access pins and collects serial data
`timescale 1ns/1ns
module jtag_prober (
  input wire logic clk_i,             // system clock used for pacing
  input wire logic tdo_i,             // serial data from the device
  output logic tck_o,                 // test clock
  output logic tms_o,                 // test mode select
  output logic tdi_o,                 // serial data to the device
  output logic debug_logic_reset_n_o  // debug logic reset, active low
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    debug_logic_reset_n_o = 1'b1;
  end

  // one test clock: 5 low and 3 high system clocks, 160 ns
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tck_o <= 1'b0;
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (5) @(posedge clk_i);
    tdo = tdo_i;
    tck_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  // idle, select, capture, shift n bits lsb first, update, idle
  task automatic frame(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic b;
    dout = '0;
    step(1'b0, 1'b0, b);
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    // clock parked low between frames; two edges let update results settle
    tck_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // debug reset held for 3 system clocks, beyond 2.5
  task automatic pulse_reset();
    debug_logic_reset_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    debug_logic_reset_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ==== tb/debug_and_boundary_scan_port_test.sv ====
// self-checking bench for the debug and boundary scan port
`timescale 1ns/1ns
module debug_and_boundary_scan_port_test;
  logic CLK_SYS_I = 1'b0;
  logic CHIP_RESET_N_I, PORT_MODE_SELECTION_I, DEBUG_LOGIC_RESET_N_I, TCK_I, TMS_I, TDI_I;
  logic TDO_O, TDO_OE_O, RETURNED_TEST_CLOCK_O, BSC_MODE_O, COMM_IRQ_O;
  logic COMM_CHANNEL_TX_FLAG_I, COMM_CHANNEL_RX_FLAG_I, SYS_ACCESS_BLOCK_I;
  logic DEBUG_SERIAL_RX_I, DEBUG_SERIAL_TX_O, SERIAL_RX_LEVEL_O, SERIAL_TX_LEVEL_I;
  logic [7:0] PAD_IN_I, CORE_PAD_OUT_I, PAD_OUT_O;
  logic [31:0] CORE_DATA_I, CHIP_ID_O;
  dbg_port_pkg::dbg_out_t DBG_O;
  int n_fail = 0;
  int n_compared = 0;
  int n_insn = 0;
  int n_dreg = 0;
  int n_returned_test_clock = 0;

  always #10 CLK_SYS_I = ~CLK_SYS_I;

  always @(posedge CLK_SYS_I) begin
    if (DBG_O.insn_valid === 1'b1) n_insn <= n_insn + 1;
    if (DBG_O.dreg_valid === 1'b1) n_dreg <= n_dreg + 1;
    if (RETURNED_TEST_CLOCK_O === 1'b1) n_returned_test_clock <= n_returned_test_clock + 1;
  end

  debug_and_boundary_scan_port dut_u (
    .CLK_SYS_I(CLK_SYS_I), .CHIP_RESET_N_I(CHIP_RESET_N_I),
    .FACTORY_TEST_PIN_I(1'b0), // held low
    .PORT_MODE_SELECTION_I(PORT_MODE_SELECTION_I),
    .DEBUG_LOGIC_RESET_N_I(DEBUG_LOGIC_RESET_N_I),
    .TCK_I(TCK_I), .TMS_I(TMS_I), .TDI_I(TDI_I), .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O),
    .RETURNED_TEST_CLOCK_O(RETURNED_TEST_CLOCK_O), .BSC_MODE_O(BSC_MODE_O),
    .PAD_IN_I(PAD_IN_I), .CORE_PAD_OUT_I(CORE_PAD_OUT_I), .PAD_OUT_O(PAD_OUT_O),
    .CORE_DATA_I(CORE_DATA_I), .DBG_O(DBG_O),
    .COMM_CHANNEL_TX_FLAG_I(COMM_CHANNEL_TX_FLAG_I),
    .COMM_CHANNEL_RX_FLAG_I(COMM_CHANNEL_RX_FLAG_I), .COMM_IRQ_O(COMM_IRQ_O),
    .SYS_ACCESS_BLOCK_I(SYS_ACCESS_BLOCK_I), .CHIP_ID_O(CHIP_ID_O),
    .DEBUG_SERIAL_RX_I(DEBUG_SERIAL_RX_I), .DEBUG_SERIAL_TX_O(DEBUG_SERIAL_TX_O),
    .SERIAL_RX_LEVEL_O(SERIAL_RX_LEVEL_O), .SERIAL_TX_LEVEL_I(SERIAL_TX_LEVEL_I)
  );

  jtag_prober prb_u (
    .clk_i(CLK_SYS_I), .tdo_i(TDO_O), .tck_o(TCK_I), .tms_o(TMS_I), .tdi_o(TDI_I),
    .debug_logic_reset_n_o(DEBUG_LOGIC_RESET_N_I)
  );

  task automatic test_done();
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic do_reset(input logic mode);
    @(posedge CLK_SYS_I);
    CHIP_RESET_N_I <= 1'b0;
    PORT_MODE_SELECTION_I <= mode;
    repeat (6) @(posedge CLK_SYS_I);
    CHIP_RESET_N_I <= 1'b1;
    repeat (24) @(posedge CLK_SYS_I);
    check(32'(TDO_OE_O), 32'h0, "idle out enable");
  endtask

  task automatic ir(input logic [3:0] code);
    logic [31:0] d;
    prb_u.frame(1'b1, dbg_port_pkg::IR_LEN, 32'(code), d);
    check(32'(d[3:0]), 32'(dbg_port_pkg::IR_CAPTURE), "ir capture");
  endtask

  task automatic s_scan_id();
    logic [31:0] d;
    prb_u.frame(1'b0, 32, 32'h0, d);
    check(d, {dbg_port_pkg::ID_VERSION, dbg_port_pkg::ID_PART, dbg_port_pkg::ID_MFR,
              1'b1}, "scan id");
    check(32'(d[0]), 32'h1, "id marker");
    check(32'(BSC_MODE_O), 32'h1, "scan mode");
  endtask

  task automatic s_bypass();
    logic [31:0] d;
    ir(dbg_port_pkg::IR_BYPASS);
    prb_u.frame(1'b0, 8, 32'hb4, d);
    check(d, 32'h68, "bypass delay");
  endtask

  task automatic s_boundary();
    logic [31:0] d;
    PAD_IN_I <= 8'h5a;
    CORE_PAD_OUT_I <= 8'hc3;
    ir(dbg_port_pkg::IR_SAMPLE);
    prb_u.frame(1'b0, dbg_port_pkg::BSR_LEN, 32'h96, d);
    check(d, 32'h5a, "sample capture");
    check(32'(PAD_OUT_O), 32'hc3, "core drives pins");
    PAD_IN_I <= 8'ha5;
    ir(dbg_port_pkg::IR_EXTEST);
    prb_u.frame(1'b0, dbg_port_pkg::BSR_LEN, 32'h3c, d);
    check(d, 32'ha5, "extest capture");
    check(32'(PAD_OUT_O), 32'h3c, "extest drive");
  endtask

  task automatic s_mode_hold();
    PORT_MODE_SELECTION_I <= 1'b0;
    repeat (10) @(posedge CLK_SYS_I);
    prb_u.pulse_reset();
    check(32'(BSC_MODE_O), 32'h1, "mode held");
    check(32'(n_returned_test_clock), 32'h0, "no returned clock");
  endtask

  task automatic s_debug_id();
    logic [31:0] d;
    check(32'(BSC_MODE_O), 32'h0, "debug mode");
    prb_u.frame(1'b0, 32, 32'h0, d);
    check(d, dbg_port_pkg::PROC_ID, "processor id");
    check(32'(n_returned_test_clock > 0), 32'h1, "returned clock");
  endtask

  task automatic s_chain();
    logic [31:0] d;
    int k;
    CORE_DATA_I <= 32'h1357_9bdf;
    ir(dbg_port_pkg::IR_SCAN_N);
    prb_u.frame(1'b0, 4, 32'(dbg_port_pkg::CHAIN_INSN), d);
    ir(dbg_port_pkg::IR_INTEST);
    k = n_insn;
    prb_u.frame(1'b0, 32, 32'hcafe_0123, d);
    check(d, 32'h1357_9bdf, "insn capture");
    check(DBG_O.insn, 32'hcafe_0123, "insn to core");
    check(32'(n_insn - k), 32'h1, "insn pulse");
    COMM_CHANNEL_TX_FLAG_I <= 1'b1;
    SYS_ACCESS_BLOCK_I <= 1'b1;
    ir(dbg_port_pkg::IR_SCAN_N);
    prb_u.frame(1'b0, 4, 32'(dbg_port_pkg::CHAIN_DREG), d);
    ir(dbg_port_pkg::IR_INTEST);
    k = n_dreg;
    prb_u.frame(1'b0, 32, 32'h0f0f_a5a5, d);
    check(d, 32'h0000_000b, "status capture");
    check(32'(n_dreg - k), 32'h0, "blocked update");
    SYS_ACCESS_BLOCK_I <= 1'b0;
    prb_u.frame(1'b0, 32, 32'h0f0f_a5a5, d);
    check(d, 32'h0000_0003, "status capture");
    check(DBG_O.dreg, 32'h0f0f_a5a5, "dreg to core");
    check(32'(n_dreg - k), 32'h1, "dreg pulse");
  endtask

  task automatic s_dbg_reset();
    logic [31:0] d;
    ir(dbg_port_pkg::IR_BYPASS);
    prb_u.pulse_reset();
    prb_u.frame(1'b0, 32, 32'h0, d);
    check(d, dbg_port_pkg::PROC_ID, "id after debug reset");
  endtask

  task automatic s_misc();
    for (int i = 0; i < 4; i++) begin
      COMM_CHANNEL_TX_FLAG_I <= i[0];
      COMM_CHANNEL_RX_FLAG_I <= i[1];
      repeat (3) @(posedge CLK_SYS_I);
      check(32'(COMM_IRQ_O), 32'(i != 0), "comm irq");
    end
    DEBUG_SERIAL_RX_I <= 1'b0;
    SERIAL_TX_LEVEL_I <= 1'b0;
    repeat (4) @(posedge CLK_SYS_I);
    check(32'(SERIAL_RX_LEVEL_O), 32'h0, "rx level");
    check(32'(DEBUG_SERIAL_TX_O), 32'h0, "tx level");
    check(CHIP_ID_O, dbg_port_pkg::CHIP_ID, "chip id");
  endtask

  initial begin
    CHIP_RESET_N_I = 1'b0;
    PORT_MODE_SELECTION_I = 1'b1;
    PAD_IN_I = 8'h00;
    CORE_PAD_OUT_I = 8'h00;
    CORE_DATA_I = 32'h0;
    COMM_CHANNEL_TX_FLAG_I = 1'b0;
    COMM_CHANNEL_RX_FLAG_I = 1'b0;
    SYS_ACCESS_BLOCK_I = 1'b0;
    DEBUG_SERIAL_RX_I = 1'b1;
    SERIAL_TX_LEVEL_I = 1'b1;
    do_reset(1'b1);
    s_scan_id();
    s_bypass();
    s_boundary();
    s_mode_hold();
    do_reset(1'b0);
    s_debug_id();
    s_chain();
    s_dbg_reset();
    s_misc();
    test_done();
  end

  // cuts a hang short
  initial begin
    repeat (60000) @(posedge CLK_SYS_I);
    n_fail++;
    test_done();
  end
endmodule
